// *** common/uog_pkg.sv ***
// package: register map, field positions, timing constants for otg control
package uog_pkg;
   // register offsets (byte index on the plain port)
   localparam logic [3:0] OFF_HWCFG  = 4'h0;
   localparam logic [3:0] OFF_GENCTL = 4'h1;
   localparam logic [3:0] OFF_GENSTA = 4'h2;
   localparam logic [3:0] OFF_GENFLG = 4'h3;
   localparam logic [3:0] OFF_ADDRH  = 4'h4;
   localparam logic [3:0] OFF_ADDRL  = 4'h5;
   localparam logic [3:0] OFF_OTGCTL = 4'h6;
   localparam logic [3:0] OFF_OTGTMR = 4'h7;
   localparam logic [3:0] OFF_OTG_IRQ_ENABLE = 4'h8;
   localparam logic [3:0] OFF_OTGFLG = 4'h9;
   localparam logic [3:0] OFF_LINK   = 4'hA;

   // reset values
   localparam logic [7:0] GENCTL_RST = 8'h20;
   localparam logic [7:0] OTGTMR_RST = 8'h80;

   // hardware config fields
   localparam int HW_SWROLE = 7;
   localparam int HW_PINROLE = 6;
   localparam int HW_SUPPIN = 4;
   localparam int HW_REGEN  = 0;
   // general control fields
   localparam int GC_ENABLE = 7;
   localparam int GC_HOST   = 6;
   localparam int GC_FREEZE = 5;
   localparam int GC_PADEN  = 4;
   localparam int GC_IDIE   = 1;
   localparam int GC_SUPIE  = 0;
   // status fields
   localparam int ST_SPEED  = 3;
   localparam int ST_ID     = 1;
   localparam int ST_SUP    = 0;
   // otg control fields
   localparam int OC_HNP    = 5;
   localparam int OC_SRP    = 4;
   localparam int OC_SESSION_METHOD_SELECT = 3;
   localparam int OC_HWCDIS = 2;
   localparam int OC_SUPON  = 1;
   localparam int OC_SUPOFF = 0;
   // timer register fields
   localparam int TM_PAGE_LO = 5;
   localparam int TM_ONE     = 7;

   // timeouts, printed unit microseconds
   localparam int CLK_MHZ = 10;
   localparam int T_AWR_US [4] = '{20000, 50000, 70000, 100000};
   localparam int T_PLS_US [4] = '{15000, 23000, 31000, 40000};
   localparam int T_PDN_US [4] = '{93000, 105000, 118000, 131000};
   localparam int T_SRP_US [4] = '{10, 100, 1000, 11000};
   localparam int SUSPEND_TO_US = 150000;
   localparam int SUSPEND_TO_CYC = SUSPEND_TO_US * CLK_MHZ;

   // otg event positions in flag and enable registers
   typedef struct packed {
      logic suspTimeout;
      logic negError;
      logic roleSwap;
      logic bconnError;
      logic supplyDrop;
      logic sessionDet;
   } uog_evt_t;

   // register bus request
   typedef struct packed {
      logic [3:0] addr;
      logic [7:0] wdata;
      logic       wr;
      logic       rd;
   } uog_bus_t;

   // analog and pin sense inputs
   typedef struct packed {
      logic idPin;
      logic supplyHighOk;
      logic sessionOk;
      logic fullSpeed;
   } uog_sense_t;
endpackage

// *** verilog/uog_otg_general_control.sv ***
// otg general control: role select, supply/id detect, timers, otg flags
//
// The address-and-strobe port and the address map were left to the implementer.
`timescale 1ns/1ps
// Operation
// - page 0 sets wait-rise timeout 20..100 ms
// - page 1 sets pulsing duration 15..40 ms
// - page 2 sets pulldown timeout 93..131 ms
// - page 3 sets session detect 10us..11ms
// - timer reg: page 6-5, value 2-0, bit7 one
// - host: supply flag hysteresis high/low inputs
// - peripheral: supply flag follows low input
// - supply change flag, gated by pad enable, not global enable
// - id change flag, independent of enable
// - role from pin or software bit
// - global enable low resets, clocks off
// - freeze gates clocks, resume detect stays
// - pad enable works with controller disabled
// - speed flag one at full speed, host role only
// - direct access uses 11-bit ram address
// - session request cleared when started
// - method bit: supply or data pulsing
// - supply on/off request drives pin
// - hw control disable of supply pin
// - negotiation request starts or accepts
// - otg event flags with same-bit enables
// - frozen: only id/supply/wake interrupts
module uog_otg_general_control
  #(parameter int SUSP_CYC = uog_pkg::SUSPEND_TO_CYC)
  (
   // clock and reset
   input  wire logic              sys_clk,
   input  wire logic              resetn,
   // register port
   input  wire uog_pkg::uog_bus_t bus,
   output logic [7:0]             rdData,
   // pins and analog sense
   input  wire uog_pkg::uog_sense_t sense,
   // otg protocol events from the link engine
   input  wire uog_pkg::uog_evt_t linkEvt,
   input  wire logic              srpStarted,
   input  wire logic              wakeEvt,
   // control outputs
   output logic                   supplyCtrlPin,
   output logic                   roleIsHost,
   output logic                   ctrlReset,
   output logic                   ctrlClkEn,
   output logic                   padEnable,
   output logic                   padRegEnable,
   output logic                   ramDirectAccess,
   output logic [10:0]            ramDirectAddress,
   output logic [22:0]            activeTimeoutCyc,
   output logic [1:0]             activeTimeoutSel,
   output logic                   sessionMethodVbus,
   output logic                   negotiationReq,
   output logic                   sessionReq,
   output logic                   generalIrq
   );
   import uog_pkg::*;

   // converts microseconds to cycles, never below one
   // the clamp keeps a zero-length timeout from firing at once
   // 23 bits cover the longest page value at 10 MHz
   function automatic logic [22:0] us2cyc(input int us);
      int c;
      c = us * CLK_MHZ;
      if (c < 1) c = 1;
      return c[22:0];
   endfunction

   // true when a write hits the given offset
   function automatic logic wrHit(input uog_bus_t b, input logic [3:0] a);
      return b.wr && (b.addr == a);
   endfunction

   logic       rstMeta_ff;
   logic       rstSync_ff;
   logic       rstn;
   logic [2:0] idSync_ff;
   logic [2:0] hiSync_ff;
   logic [2:0] loSync_ff;
   logic       idStable_ff;
   logic       hiStable_ff;
   logic       loStable_ff;
   logic [7:0] hwCfg_ff;
   logic [7:0] genCtl_ff;
   logic [1:0] genFlg_ff;
   logic [2:0] addrH_ff;
   logic [7:0] addrL_ff;
   logic       ram_direct_access_ff;
   logic [5:0] otgCtl_ff;
   logic [1:0] tmPage_ff;
   logic [2:0] tmVal_ff;
   logic [1:0] tmSel_ff [4];
   logic [5:0] otg_irq_enable_ff;
   logic [5:0] otgFlg_ff;
   logic       supply_ff;
   logic       supplyPrev_ff;
   logic [7:0] rdData_ff;
   logic [27:0] suspCnt_ff;
   logic       nxt_supply;
   logic       hostRole;
   logic       frozen;
   logic       enabled;
   logic [5:0] otgSet;
   logic       idChange;
   logic       supChange;
   logic [7:0] nxt_rd;

   // reset release through two flops
   // assertion stays asynchronous, only the release is timed
   // so no flop leaves reset a cycle before its neighbour
   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         rstMeta_ff <= 1'b0;
         rstSync_ff <= 1'b0;
      end else begin
         rstMeta_ff <= 1'b1;
         rstSync_ff <= rstMeta_ff;
      end
   end
   assign rstn = rstSync_ff;

   // three-stage pin sync; stable value moves when stages 2 and 3 agree
   // stage 1 may be metastable and is read by the shift only
   // a glitch shorter than one cycle never reaches the flags
   // latency from pin edge to id flag is three to four cycles, to supply change flag five to six
   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         idSync_ff   <= 3'h7;
         hiSync_ff   <= 3'h0;
         loSync_ff   <= 3'h0;
         idStable_ff <= 1'b1;
         hiStable_ff <= 1'b0;
         loStable_ff <= 1'b0;
      end else begin
         idSync_ff <= {idSync_ff[1:0], sense.idPin};
         hiSync_ff <= {hiSync_ff[1:0], sense.supplyHighOk};
         loSync_ff <= {loSync_ff[1:0], sense.sessionOk};
         if (idSync_ff[1] == idSync_ff[2]) idStable_ff <= idSync_ff[2];
         if (hiSync_ff[1] == hiSync_ff[2]) hiStable_ff <= hiSync_ff[2];
         if (loSync_ff[1] == loSync_ff[2]) loStable_ff <= loSync_ff[2];
      end
   end

   // role: pin high (no a-plug) means peripheral
   // the pin path uses the filtered copy, so a bouncing plug
   // cannot toggle the role faster than the flag can follow
   always_comb begin
      if (hwCfg_ff[HW_PINROLE]) hostRole = ~idStable_ff;
      else                      hostRole = ~hwCfg_ff[HW_SWROLE];
   end
   // pin mode is only sampled, software keeps it steady while disabled
   assign roleIsHost = hostRole;
   assign enabled    = genCtl_ff[GC_ENABLE];
   assign frozen     = genCtl_ff[GC_FREEZE];
   assign ctrlReset  = ~enabled;
   assign ctrlClkEn  = enabled & ~frozen;
   assign padEnable  = genCtl_ff[GC_PADEN];
   assign padRegEnable = hwCfg_ff[HW_REGEN];

   // supply-present flag: hysteresis in host, follow in peripheral
   always_comb begin
      nxt_supply = supply_ff;
      if (!padEnable) nxt_supply = 1'b0;
      else if (hostRole) begin
         if (hiStable_ff)       nxt_supply = 1'b1;
         else if (!loStable_ff) nxt_supply = 1'b0;
      end else begin
         nxt_supply = loStable_ff;
      end
   end
   // one-cycle pulse on each move of the supply flag
   assign supChange = supply_ff ^ supplyPrev_ff;

   // id edge: only when stages agree and differ from the stable copy
   // ties the flag to the same cycle the stable copy moves
   always_comb begin
      idChange = (idSync_ff[1] == idSync_ff[2])
               & (idSync_ff[2] != idStable_ff);
   end

   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         supply_ff     <= 1'b0;
         supplyPrev_ff <= 1'b0;
      end else begin
         supply_ff     <= nxt_supply;
         supplyPrev_ff <= supply_ff;
      end
   end

   // hardware config register, not reset by global enable
   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) hwCfg_ff <= 8'h00;
      else if (wrHit(bus, OFF_HWCFG))
         hwCfg_ff <= bus.wdata & 8'hD1;
   end

   // general control; pad enable writable regardless of enable
   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) genCtl_ff <= GENCTL_RST;
      else if (wrHit(bus, OFF_GENCTL))
         genCtl_ff <= bus.wdata & 8'hF3;
   end

   // id and supply transition flags; set beats a clear write
   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) genFlg_ff <= 2'h0;
      else begin
         for (int i = 0; i < 2; i++) begin
            if (wrHit(bus, OFF_GENFLG) && !bus.wdata[i])
               genFlg_ff[i] <= 1'b0;
         end
         if (idChange)  genFlg_ff[1] <= 1'b1;
         if (supChange) genFlg_ff[0] <= 1'b1;
      end
   end

   // direct ram access address; auto-increment left to data path
   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         ram_direct_access_ff <= 1'b0;
         addrH_ff <= 3'h0;
         addrL_ff <= 8'h00;
      end else begin
         if (wrHit(bus, OFF_ADDRH)) begin
            ram_direct_access_ff <= bus.wdata[7];
            addrH_ff <= bus.wdata[2:0];
         end
         if (wrHit(bus, OFF_ADDRL)) addrL_ff <= bus.wdata;
      end
   end
   assign ramDirectAccess  = ram_direct_access_ff;
   assign ramDirectAddress = {addrH_ff, addrL_ff};

   // otg control; whole block held reset while disabled
   // software must re-arm every request after a re-enable
   // the off request bit is a strobe and never reads back set
   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) otgCtl_ff <= 6'h00;
      else if (!enabled) otgCtl_ff <= 6'h00;
      else begin
         if (wrHit(bus, OFF_OTGCTL)) begin
            otgCtl_ff[5:2] <= bus.wdata[5:2];
            if (bus.wdata[OC_SRP] && hostRole)
               otgCtl_ff[OC_SRP] <= 1'b0;
            if (bus.wdata[OC_SUPON]) otgCtl_ff[OC_SUPON] <= 1'b1;
         end
         if (srpStarted) otgCtl_ff[OC_SRP] <= 1'b0;
         // off request wins and never stays stored
         if (wrHit(bus, OFF_OTGCTL) && bus.wdata[OC_SUPOFF])
            otgCtl_ff[OC_SUPON] <= 1'b0;
         otgCtl_ff[OC_SUPOFF] <= 1'b0;
      end
   end
   assign negotiationReq    = otgCtl_ff[OC_HNP];
   assign sessionReq        = otgCtl_ff[OC_SRP];
   assign sessionMethodVbus = otgCtl_ff[OC_SESSION_METHOD_SELECT];

   // supply pin: request bit, plus hardware drop-off unless disabled
   // a supply drop cuts the pin at once, before software reacts
   always_comb begin
      supplyCtrlPin = otgCtl_ff[OC_SUPON] & hwCfg_ff[HW_SUPPIN];
      if (!otgCtl_ff[OC_HWCDIS] && otgFlg_ff[1])
         supplyCtrlPin = 1'b0;
   end

   // timer page/value; each page keeps its own value
   // a read shows only the last page written, not all four
   // value bit 2 is stored for read-back but selects nothing
   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         tmPage_ff <= 2'h0;
         tmVal_ff  <= 3'h0;
         for (int p = 0; p < 4; p++) tmSel_ff[p] <= 2'h0;
      end else if (wrHit(bus, OFF_OTGTMR)) begin
         tmPage_ff <= bus.wdata[6:5];
         tmVal_ff  <= bus.wdata[2:0];
         tmSel_ff[bus.wdata[6:5]] <= bus.wdata[1:0];
      end
   end

   // timeout of the page being viewed, in cycles
   always_comb begin
      activeTimeoutSel = tmSel_ff[tmPage_ff];
      unique case (tmPage_ff)
         2'h0: activeTimeoutCyc = us2cyc(T_AWR_US[activeTimeoutSel]);
         2'h1: activeTimeoutCyc = us2cyc(T_PLS_US[activeTimeoutSel]);
         2'h2: activeTimeoutCyc = us2cyc(T_PDN_US[activeTimeoutSel]);
         2'h3: activeTimeoutCyc = us2cyc(T_SRP_US[activeTimeoutSel]);
      endcase
   end

   // suspend watchdog; counts only while clocks run
   // saturates so the flag is raised once per suspend
   // freezing restarts the count, trading accuracy for power
   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) suspCnt_ff <= 28'h0;
      else if (!ctrlClkEn || !linkEvt.suspTimeout) suspCnt_ff <= 28'h0;
      else if (suspCnt_ff != SUSP_CYC[27:0]) suspCnt_ff <= suspCnt_ff + 28'h1;
   end

   // otg events; none raised while frozen or disabled
   always_comb begin
      otgSet = {(suspCnt_ff == SUSP_CYC[27:0] - 28'h1) & linkEvt.suspTimeout,
                linkEvt.negError, linkEvt.roleSwap, linkEvt.bconnError,
                linkEvt.supplyDrop, linkEvt.sessionDet};
      if (!ctrlClkEn) otgSet = 6'h00;
   end

   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         otg_irq_enable_ff <= 6'h00;
         otgFlg_ff <= 6'h00;
      end else begin
         if (wrHit(bus, OFF_OTG_IRQ_ENABLE)) otg_irq_enable_ff <= bus.wdata[5:0];
         for (int i = 0; i < 6; i++) begin
            if (wrHit(bus, OFF_OTGFLG) && !bus.wdata[i])
               otgFlg_ff[i] <= 1'b0;
            if (otgSet[i]) otgFlg_ff[i] <= 1'b1;
         end
      end
   end

   // single request line; wake path stays live under freeze
   assign generalIrq = |(genFlg_ff & genCtl_ff[1:0])
                     | (|(otgFlg_ff & otg_irq_enable_ff))
                     | (wakeEvt & frozen);

   // read mux
   // unmapped offsets and reserved bits read as zero
   // speed bit masked in device role, where it means nothing
   always_comb begin
      nxt_rd = 8'h00;
      unique case (bus.addr)
         OFF_HWCFG:  nxt_rd = hwCfg_ff;
         OFF_GENCTL: nxt_rd = genCtl_ff;
         OFF_GENSTA: nxt_rd = {4'h0, sense.fullSpeed & hostRole, 1'b0,
                               idStable_ff, supply_ff};
         OFF_GENFLG: nxt_rd = {6'h00, genFlg_ff};
         OFF_ADDRH:  nxt_rd = {ram_direct_access_ff, 4'h0, addrH_ff};
         OFF_ADDRL:  nxt_rd = addrL_ff;
         OFF_OTGCTL: nxt_rd = {2'h0, otgCtl_ff};
         OFF_OTGTMR: nxt_rd = {1'b1, tmPage_ff, 2'h0, tmVal_ff};
         OFF_OTG_IRQ_ENABLE: nxt_rd = {2'h0, otg_irq_enable_ff};
         OFF_OTGFLG: nxt_rd = {2'h0, otgFlg_ff};
         default:    nxt_rd = 8'h00;
      endcase
   end

   // read data one cycle after strobe, only then
   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) rdData_ff <= 8'h00;
      else if (bus.rd) rdData_ff <= nxt_rd;
      else rdData_ff <= 8'h00;
   end
   assign rdData = rdData_ff;
endmodule

// *** verification/uog_cable_partner.sv ***
// cable partner model: id pin and supply comparators toward the block
`timescale 1ns/1ps
module uog_cable_partner
  (
   // cable state set by the bench
   input  wire logic          aPlug,
   input  wire logic [1:0]    level,
   input  wire logic          fullSpd,
   // raw sense lines
   output uog_pkg::uog_sense_t sense
   );
   import uog_pkg::*;
   // id pulled up without a-plug; high threshold implies the low one
   assign #7 sense = '{!aPlug, level == 2'h2, level != 2'h0, fullSpd};
endmodule

// *** verification/uog_otg_general_control_asserts.sv ***
// checker: register side effects seen at the top ports
`timescale 1ns/1ps
module uog_otg_checks
  #(parameter int SUSP_CYC = 20)
  (
   // clock, reset
   input wire logic              sys_clk,
   input wire logic              resetn,
   // register port
   input wire uog_pkg::uog_bus_t bus,
   input wire logic [7:0]        rdData,
   // watched outputs and events
   input wire logic              srpStarted,
   input wire logic              supplyCtrlPin,
   input wire logic              ctrlReset,
   input wire logic              ctrlClkEn,
   input wire logic              padEnable,
   input wire logic              ramDirectAccess,
   input wire logic [10:0]       ramDirectAddress,
   input wire logic [22:0]       activeTimeoutCyc,
   input wire logic [1:0]        activeTimeoutSel,
   input wire logic              sessionReq
   );
   import uog_pkg::*;
   logic gw, tw, ow, hw, lw;
   default clocking @(posedge sys_clk); endclocking
   default disable iff (!resetn);
   // write strobes per register
   assign gw = bus.wr && bus.addr == OFF_GENCTL;
   assign tw = bus.wr && bus.addr == OFF_OTGTMR;
   assign ow = bus.wr && bus.addr == OFF_OTGCTL;
   assign hw = bus.wr && bus.addr == OFF_ADDRH;
   assign lw = bus.wr && bus.addr == OFF_ADDRL;
   // timeout cycles for a timer write
   function automatic logic [22:0] tmo(logic [7:0] d);
      int us;
      case (d[6:5])
         2'h0: us = T_AWR_US[d[1:0]];
         2'h1: us = T_PLS_US[d[1:0]];
         2'h2: us = T_PDN_US[d[1:0]];
         default: us = T_SRP_US[d[1:0]];
      endcase
      return 23'(us * CLK_MHZ);
   endfunction
   a_reset_follows_enable:
      assert property (gw |=> ctrlReset == !$past(bus.wdata[7]))
      else $error("reset output wrong after control write");
   a_clock_gate_freeze:
      assert property (gw |=> ctrlClkEn ==
         ($past(bus.wdata[7]) && !$past(bus.wdata[5])))
      else $error("clock enable wrong after control write");
   a_pad_enable_any:
      assert property (gw |=> padEnable == $past(bus.wdata[4]))
      else $error("pad enable wrong after control write");
   a_timer_fixed_bits:
      assert property (bus.rd && bus.addr == OFF_OTGTMR
         |=> rdData[7] && rdData[4:3] == 2'h0)
      else $error("timer fixed bits wrong");
   a_timeout_table:
      assert property (tw |=> activeTimeoutCyc == tmo($past(bus.wdata))
         && activeTimeoutSel == $past(bus.wdata[1:0]))
      else $error("timeout selection wrong");
   a_supply_off_req:
      assert property (ow && bus.wdata[0] |=> !supplyCtrlPin)
      else $error("supply pin still on after off request");
   a_session_clear:
      assert property (srpStarted && !ow |=> !sessionReq)
      else $error("session request not cleared when started");
   a_ram_addr_low:
      assert property (lw |=> ramDirectAddress[7:0] == $past(bus.wdata))
      else $error("ram address low part wrong");
   a_ram_addr_high:
      assert property (hw |=> ramDirectAccess == $past(bus.wdata[7])
         && ramDirectAddress[10:8] == $past(bus.wdata[2:0]))
      else $error("ram direct access or high address wrong");
   a_ram_addr_hold:
      assert property (!hw && !lw |=> $stable(ramDirectAddress))
      else $error("ram address moved without a write");
   c_timer_write: cover property (tw);
   c_session_start: cover property (srpStarted && sessionReq);
   c_supply_off: cover property (ow && bus.wdata[0]);
endmodule
bind uog_otg_general_control uog_otg_checks #(.SUSP_CYC(SUSP_CYC))
   i_uog_otg_checks (.sys_clk, .resetn, .bus, .rdData, .srpStarted,
   .supplyCtrlPin, .ctrlReset, .ctrlClkEn, .padEnable, .ramDirectAccess,
   .ramDirectAddress, .activeTimeoutCyc, .activeTimeoutSel, .sessionReq);

// *** verification/uog_otg_general_control_bench.sv ***
// bench: otg general control against a register model
`timescale 1ns/1ps
module uog_otg_general_control_bench;
   import uog_pkg::*;
   localparam int SC = 20;
   logic sys_clk, resetn, srpStarted, wakeEvt, aPlug, fullSpd;
   logic pin, host, cRst, cClk, pad, ramAcc, mVbus, hnp, srp, irq, regEn;
   logic [1:0] level, tSel;
   logic [7:0] rdData, v;
   logic [10:0] ramAdr;
   logic [22:0] tCyc;
   uog_bus_t bus;
   uog_evt_t linkEvt;
   uog_sense_t sense;
   int err_total, n_tests, seed, sup, old, mdl [16], us [16];
   uog_otg_general_control #(.SUSP_CYC(SC)) i_uog_otg_general_control (
      .sys_clk, .resetn, .bus, .rdData, .sense, .linkEvt, .srpStarted,
      .wakeEvt, .supplyCtrlPin(pin), .roleIsHost(host), .ctrlReset(cRst),
      .ctrlClkEn(cClk), .padEnable(pad), .padRegEnable(regEn),
      .ramDirectAccess(ramAcc), .ramDirectAddress(ramAdr),
      .activeTimeoutCyc(tCyc), .activeTimeoutSel(tSel),
      .sessionMethodVbus(mVbus), .negotiationReq(hnp), .sessionReq(srp),
      .generalIrq(irq));
   uog_cable_partner i_uog_cable_partner (.aPlug, .level, .fullSpd, .sense);
   // 100 ns clock
   initial begin
      sys_clk = 1'b0;
      forever #50 sys_clk = ~sys_clk;
   end
   task automatic check(input logic [31:0] s, e);
      n_tests++;
      if (s !== e) begin
         err_total++;
         $display("BAD t=%0t seen=%h exp=%h", $time, s, e);
      end
   endtask
   task automatic print_verdict;
      $display("TB: checks=%0d errors=%0d", n_tests, err_total);
      if (err_total == 0 && n_tests > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask
   // write, then update the model as the register should
   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      @(posedge sys_clk) bus <= '{a, d, 1'b1, 1'b0};
      @(posedge sys_clk) bus <= '0;
      @(negedge sys_clk);
      case (a)
         OFF_GENCTL: mdl[a] = d & 8'hF3;
         OFF_ADDRH: mdl[a] = d & 8'h87;
         OFF_ADDRL: mdl[a] = d;
         OFF_OTG_IRQ_ENABLE: mdl[a] = d & 8'h3F;
         OFF_OTGTMR: mdl[a] = d & 8'h67 | 8'h80;
         OFF_OTGCTL: mdl[a] = d & (d[0] ? 8'h3C : 8'h3E);
         OFF_GENFLG, OFF_OTGFLG: mdl[a] = mdl[a] & d;
         default: ;
      endcase
   endtask
   // read data looked at in the one cycle it stands
   task automatic rd(input logic [3:0] a);
      @(posedge sys_clk) bus <= '{a, 8'h00, 1'b0, 1'b1};
      @(posedge sys_clk) bus <= '0;
      @(negedge sys_clk) check(32'(rdData), mdl[a]);
   endtask
   // a hang counts as a mismatch
   initial begin
      #5000000;
      err_total++;
      print_verdict();
   end
   initial begin
      seed = 32'h192351bd;
      bus = '0;
      linkEvt = '0;
      {srpStarted, wakeEvt, aPlug, fullSpd, level, resetn} = 7'h08;
      mdl = '{default: 0};
      mdl[OFF_GENCTL] = 8'h20;
      mdl[OFF_OTGTMR] = 8'h80;
      us = '{20000, 50000, 70000, 100000, 15000, 23000, 31000, 40000,
             93000, 105000, 118000, 131000, 10, 100, 1000, 11000};
      repeat (3) @(posedge sys_clk);
      resetn <= 1'b1;
      repeat (3) @(posedge sys_clk);
      check(32'({cRst, cClk}), 2'b10);
      wr(4'hB, 8'($random(seed)));
      for (int a = 1; a < 16; a++) if (a != 2 && a != 10) rd(4'(a));
      // every page and code, reserved bits random
      for (int i = 0; i < 16; i++) begin
         v = 8'($random(seed));
         wr(OFF_OTGTMR, {v[7], 2'(i >> 2), v[4:2], 2'(i)});
         rd(OFF_OTGTMR);
         check(32'(tCyc), us[i] * CLK_MHZ);
         check(32'(tSel), i & 3);
      end
      wr(OFF_GENCTL, 8'h30);
      check(32'({cRst, cClk, pad}), 3'b101);
      wr(OFF_GENCTL, 8'h90);
      check(32'({cRst, cClk, pad}), 3'b011);
      // peripheral: flag follows the low threshold
      wr(OFF_HWCFG, 8'h90);
      check(32'(host), 0);
      @(posedge sys_clk) level <= 2'h1;
      repeat (8) @(posedge sys_clk);
      mdl[OFF_GENSTA] = 8'h03;
      mdl[OFF_GENFLG] = 8'h01;
      rd(OFF_GENSTA);
      wr(OFF_GENFLG, 8'h03);
      rd(OFF_GENFLG);
      check(32'(irq), 0);
      wr(OFF_GENCTL, 8'h91);
      check(32'(irq), 1);
      wr(OFF_GENFLG, 8'h00);
      check(32'(irq), 0);
      // host: hysteresis between the two thresholds
      wr(OFF_HWCFG, 8'h10);
      check(32'(host), 1);
      sup = 1;
      for (int i = 0; i < 5; i++) begin
         @(posedge sys_clk) level <= 2'(i == 2 ? 2 : i & 1);
         repeat (8) @(posedge sys_clk);
         old = sup;
         sup = level == 2'h2 ? 1 : (level == 2'h0 ? 0 : sup);
         mdl[OFF_GENSTA] = 8'h0A | sup;
         mdl[OFF_GENFLG] = int'(sup != old);
         rd(OFF_GENSTA);
         rd(OFF_GENFLG);
         wr(OFF_GENFLG, 8'h00);
      end
      // otg control in device role
      wr(OFF_HWCFG, 8'h90);
      wr(OFF_OTGCTL, 8'h2A);
      check(32'({pin, mVbus, hnp}), 3'b111);
      wr(OFF_OTGCTL, 8'h01);
      check(32'(pin), 0);
      rd(OFF_OTGCTL);
      wr(OFF_OTGCTL, 8'h14);
      check(32'({srp, mVbus}), 2'b10);
      @(posedge sys_clk) srpStarted <= 1'b1;
      @(posedge sys_clk) srpStarted <= 1'b0;
      mdl[OFF_OTGCTL] = 8'h04;
      rd(OFF_OTGCTL);
      // each otg event sets its flag, gated by its enable
      wr(OFF_GENCTL, 8'h90);
      for (int i = 0; i < 6; i++) begin
         @(posedge sys_clk) linkEvt <= 6'(1 << i);
         repeat (i == 5 ? SC + 4 : 1) @(posedge sys_clk);
         linkEvt <= '0;
         mdl[OFF_OTGFLG] = 1 << i;
         rd(OFF_OTGFLG);
         check(32'(irq), 0);
         wr(OFF_OTG_IRQ_ENABLE, 8'(1 << i));
         check(32'(irq), 1);
         wr(OFF_OTGFLG, 8'h00);
         check(32'(irq), 0);
      end
      // frozen: otg events ignored, wake still passes
      wr(OFF_GENCTL, 8'hA0);
      wr(OFF_OTG_IRQ_ENABLE, 8'h3F);
      @(posedge sys_clk) linkEvt <= 6'h1F;
      @(posedge sys_clk) linkEvt <= '0;
      rd(OFF_OTGFLG);
      check(32'(irq), 0);
      @(posedge sys_clk) wakeEvt <= 1'b1;
      @(negedge sys_clk) check(32'(irq), 1);
      @(posedge sys_clk) wakeEvt <= 1'b0;
      // id pin role, pin mode changed only while disabled
      wr(OFF_GENCTL, 8'h12);
      wr(OFF_HWCFG, 8'h51);
      check(32'(regEn), 1);
      @(posedge sys_clk) aPlug <= 1'b1;
      repeat (8) @(posedge sys_clk);
      mdl[OFF_GENFLG] = 8'h02;
      rd(OFF_GENFLG);
      check(32'(host), 1);
      // direct ram address, usable while disabled
      v = 8'($random(seed));
      wr(OFF_ADDRH, 8'hFD);
      wr(OFF_ADDRL, v);
      check(32'({ramAcc, ramAdr}), {1'b1, 3'h5, v});
      rd(OFF_ADDRH);
      print_verdict();
   end
endmodule
